// *** verilog/sshp_host_port.v ***
// Purpose: Processor bus port, loopback and receiver of a sync serial controller.
// Assumes: All pins are asynchronous to CLK; serial clocks are sampled, not clocks.
// Notes: Every input but CLK and RST_N passes two flops, so a bus cycle lands a few clocks after its strobe.
`include "sshp_map.vh"
`default_nettype none

module sshp_host_port (
    input wire CLK,
    input wire RST_N,
    input wire RESET,
    input wire [15:0] HOST_DATA_IN,
    output reg [15:0] HOST_DATA_OUT,
    output wire [15:0] HOST_DATA_OE,
    input wire [2:0] REGISTER_SELECT_LINES,
    input wire BYTE_MODE,
    input wire CHIP_ENABLE,
    input wire READ_WRITE,
    input wire BUS_STROBE,
    input wire LOOPBACK_TEST_MODE,
    input wire RECEIVER_ENABLE_IN,
    input wire SERIAL_IN,
    input wire RECEIVE_CLOCK,
    input wire TRANSMIT_CLOCK,
    output reg SERIAL_OUT,
    output reg TRANSMIT_BUFFER_EMPTY,
    output reg RECEIVE_DATA_AVAILABLE
);

    // ---------------------------------------------------------------------------
    // Synchronisers for every input pin but CLK and RST_N.
    // ---------------------------------------------------------------------------
    wire [28:0] raw_pins; // All asynchronous inputs, grouped.
    wire [28:0] pins; // Their synchronised copies.
    assign raw_pins = {HOST_DATA_IN, REGISTER_SELECT_LINES, BYTE_MODE, CHIP_ENABLE,
                       READ_WRITE, BUS_STROBE, LOOPBACK_TEST_MODE, RECEIVER_ENABLE_IN,
                       SERIAL_IN, RECEIVE_CLOCK, TRANSMIT_CLOCK, RESET};

    sshp_sync2 #(.WIDTH(29)) u_sync (
        .CLK(CLK),
        .RST_N(RST_N),
        .D(raw_pins),
        .Q(pins)
    );

    wire [15:0] s_data = pins[28:13]; // Synchronised bus data.
    wire [2:0] s_sel = pins[12:10]; // Synchronised register select.
    wire s_byte = pins[9]; // High selects single-byte transfers.
    wire s_ce = pins[8]; // Chip enable.
    wire s_rw = pins[7]; // High is a write.
    wire s_strobe = pins[6]; // Bus strobe level.
    wire s_mm = pins[5]; // Loopback test mode.
    wire s_rxe = pins[4]; // Receiver enable.
    wire s_rxd = pins[3]; // External serial data.
    wire s_rxc = pins[2]; // External receive clock.
    wire s_txc = pins[1]; // Transmit clock.
    wire s_reset = pins[0]; // Synchronised device reset, high active.

    // ---------------------------------------------------------------------------
    // Register file.
    // ---------------------------------------------------------------------------
    reg [15:0] rx_reg; // Receive data (low) and status (high).
    reg [15:0] ctrl_a; // Protocol and character length control.
    reg [15:0] ctrl_b; // Spare control word.
    reg [15:0] tx_reg; // Transmit data (low) and control (high).
    reg strobe_q; // Previous strobe level for edge detection.
    reg [15:0] rd_word; // Selected word before byte steering.

    wire [1:0] word_sel = s_sel[2:1]; // Word index.
    wire bus_active = s_ce & s_strobe; // Cycle in progress. gating.
    wire strobe_rise = s_strobe & ~strobe_q & s_ce;
    wire wr_pulse = strobe_rise & s_rw;
    wire rd_pulse = strobe_rise & ~s_rw;
    // In byte mode select bit 0 high picks the high byte, else the low byte.
    wire lo_lane = ~s_byte | ~s_sel[0];
    wire hi_lane = ~s_byte | s_sel[0];

    // Float the bus whenever chip enable or strobe is low; read drives it.
    assign HOST_DATA_OE = (bus_active & ~s_rw) ? 16'hffff : 16'h0000;

    // Pick the addressed word.
    always @* begin
        case (word_sel)
            `SSHP_SEL_RX_DATA_STATUS: rd_word = rx_reg;
            `SSHP_SEL_CTRL_A: rd_word = ctrl_a;
            `SSHP_SEL_CTRL_B: rd_word = ctrl_b;
            `SSHP_SEL_TX_DATA_STATUS: rd_word = tx_reg;
            default: rd_word = `SSHP_RESET_WORD;
        endcase
    end

    // Read data from flops. A byte read drives its own lane and zeros on the other,
    // so that an 8-bit host with wired-OR lanes sees the byte cleanly.
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            HOST_DATA_OUT <= 16'h0000;
        end else if (!s_byte) begin
            HOST_DATA_OUT <= rd_word;
        end else if (s_sel[0]) begin
            HOST_DATA_OUT <= {rd_word[15:8], 8'h00};
        end else begin
            HOST_DATA_OUT <= {8'h00, rd_word[7:0]};
        end
    end

    // ---------------------------------------------------------------------------
    // Loopback and receiver sampling.
    // ---------------------------------------------------------------------------
    reg tx_line; // Internal transmit data line.
    wire rx_data = s_mm ? tx_line : s_rxd;
    wire rx_clk_lvl = s_mm ? s_txc : s_rxc;
    reg rx_clk_q; // Last receive clock level.
    reg txc_q; // Last transmit clock level.
    wire rx_edge = rx_clk_lvl & ~rx_clk_q; // Rising receive edge.
    wire tx_edge = s_txc & ~txc_q; // Rising transmit edge.

    // Character length: 0 encodes 8. Byte-control mode forces at least 5.
    wire [3:0] raw_len = (ctrl_a[`SSHP_CTRL_LEN_MSB:`SSHP_CTRL_LEN_LSB] == 3'h0) ? 4'h8 :
                         {1'b0, ctrl_a[`SSHP_CTRL_LEN_MSB:`SSHP_CTRL_LEN_LSB]};
    wire bit_oriented_protocol = ctrl_a[`SSHP_CTRL_BOP_BIT]; // Bit-oriented mode.
    wire [3:0] char_len = (!bit_oriented_protocol && raw_len < `SSHP_BCP_MIN_LEN) ?
                          `SSHP_BCP_MIN_LEN : raw_len;

    reg [7:0] rx_shift; // Receive assembly shifter.
    reg [3:0] rx_count; // Bits gathered so far.
    reg [3:0] tx_count; // Bits left in the transmit character.
    reg [7:0] tx_shift; // Transmit shifter.
    reg tx_full; // Transmit register holds an unsent character.

    // Main sequential process: bus writes, status and serial engines.
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            strobe_q <= 1'b0;
            rx_reg <= `SSHP_RESET_WORD;
            ctrl_a <= `SSHP_RESET_WORD;
            ctrl_b <= `SSHP_RESET_WORD;
            tx_reg <= `SSHP_RESET_WORD;
            rx_clk_q <= 1'b0;
            txc_q <= 1'b0;
            rx_shift <= 8'h00;
            rx_count <= 4'h0;
            tx_count <= 4'h0;
            tx_shift <= 8'h00;
            tx_full <= 1'b0;
            tx_line <= 1'b1;
            SERIAL_OUT <= 1'b1;
            TRANSMIT_BUFFER_EMPTY <= 1'b0;
            RECEIVE_DATA_AVAILABLE <= 1'b0;
        end else if (s_reset) begin
            // Device reset pin returns the registers and counters to reset values; the clock level trackers keep sampling.
            strobe_q <= 1'b0;
            rx_reg <= `SSHP_RESET_WORD;
            ctrl_a <= `SSHP_RESET_WORD;
            ctrl_b <= `SSHP_RESET_WORD;
            tx_reg <= `SSHP_RESET_WORD;
            rx_shift <= 8'h00;
            rx_count <= 4'h0;
            tx_count <= 4'h0;
            tx_shift <= 8'h00;
            tx_full <= 1'b0;
            tx_line <= 1'b1;
            SERIAL_OUT <= 1'b1;
            TRANSMIT_BUFFER_EMPTY <= 1'b0;
            RECEIVE_DATA_AVAILABLE <= 1'b0;
            rx_clk_q <= rx_clk_lvl;
            txc_q <= s_txc;
        end else begin
            strobe_q <= s_strobe;
            rx_clk_q <= rx_clk_lvl;
            txc_q <= s_txc;
            // Host writes, byte lanes per transfer size.
            if (wr_pulse) begin
                case (word_sel)
                    `SSHP_SEL_CTRL_A: begin
                        if (lo_lane) ctrl_a[7:0] <= s_data[7:0];
                        if (hi_lane) ctrl_a[15:8] <= s_data[15:8];
                    end
                    `SSHP_SEL_CTRL_B: begin
                        if (lo_lane) ctrl_b[7:0] <= s_data[7:0];
                        if (hi_lane) ctrl_b[15:8] <= s_data[15:8];
                    end
                    `SSHP_SEL_TX_DATA_STATUS: begin
                        if (lo_lane) tx_reg[7:0] <= s_data[7:0];
                        if (hi_lane) tx_reg[15:8] <= s_data[15:8];
                    end
                    default: begin
                        // Receive word is read-only; writes are dropped.
                    end
                endcase
            end
            // Transmitter: load shifter from register on a clock edge.
            if (tx_edge) begin
                if (tx_count != 4'h0) begin
                    tx_line <= tx_shift[0];
                    tx_shift <= {1'b1, tx_shift[7:1]};
                    tx_count <= tx_count - 4'h1;
                end else if (tx_full) begin
                    tx_shift <= tx_reg[7:0];
                    tx_count <= char_len;
                    tx_full <= 1'b0;
                end else begin
                    tx_line <= 1'b1;
                end
            end
            // A host load wins over the shifter emptying the register.
            if (wr_pulse && word_sel == `SSHP_SEL_TX_DATA_STATUS) begin
                tx_full <= 1'b1;
                TRANSMIT_BUFFER_EMPTY <= 1'b0;
            end else if (tx_edge && tx_count == 4'h0 && tx_full) begin
                TRANSMIT_BUFFER_EMPTY <= 1'b1;
            end else if (!tx_full && tx_count == 4'h0) begin
                TRANSMIT_BUFFER_EMPTY <= 1'b1;
            end
            SERIAL_OUT <= s_mm ? 1'b1 : tx_line;
            // Receiver: enable low returns all receiver state to start.
            if (!s_rxe) begin
                rx_shift <= 8'h00;
                rx_count <= 4'h0;
                rx_reg <= `SSHP_RESET_WORD;
                RECEIVE_DATA_AVAILABLE <= 1'b0;
            end else begin
                if (rx_edge) begin
                    rx_shift <= {rx_data, rx_shift[7:1]};
                    if (rx_count + 4'h1 >= char_len) begin
                        rx_count <= 4'h0;
                        // Right-justify the assembled character.
                        rx_reg[7:0] <= {rx_data, rx_shift[7:1]} >> (4'h8 - char_len);
                        // Overrun if the previous character was unread.
                        rx_reg[`SSHP_RX_STAT_OVR_BIT] <= RECEIVE_DATA_AVAILABLE;
                    end else begin
                        rx_count <= rx_count + 4'h1;
                    end
                end
                // A new character beats a simultaneous read clear.
                if (rx_edge && rx_count + 4'h1 >= char_len) begin
                    RECEIVE_DATA_AVAILABLE <= 1'b1;
                end else if (rd_pulse && word_sel == `SSHP_SEL_RX_DATA_STATUS && lo_lane) begin
                    RECEIVE_DATA_AVAILABLE <= 1'b0;
                end
            end
        end
    end

endmodule // sshp_host_port
`default_nettype wire

// *** verilog/sshp_map.vh ***
// Purpose: Constants for the synchronous serial controller host port.
// Assumes: Included by the host port modules only.
// Notes: Register selects are word indices; bit 0 picks the byte in byte mode.
`ifndef SSHP_MAP_VH
`define SSHP_MAP_VH

// ---------------------------------------------------------------------------
// Register selects (upper two select lines pick the word).
// ---------------------------------------------------------------------------
`define SSHP_SEL_RX_DATA_STATUS 2'h0
`define SSHP_SEL_CTRL_A 2'h1
`define SSHP_SEL_CTRL_B 2'h2
`define SSHP_SEL_TX_DATA_STATUS 2'h3

// ---------------------------------------------------------------------------
// Field positions, reset values and the byte-control minimum length.
// ---------------------------------------------------------------------------
`define SSHP_CTRL_BOP_BIT 15
`define SSHP_CTRL_LEN_LSB 8
`define SSHP_CTRL_LEN_MSB 10
`define SSHP_RX_STAT_OVR_BIT 8
`define SSHP_RESET_WORD 16'h0000
`define SSHP_BCP_MIN_LEN 4'h5

`endif

// *** verilog/sshp_sync2.v ***
// Purpose: Two flip-flop synchroniser for a level from outside the clock domain.
// Assumes: One clock CLK, asynchronous active-low reset.
// Notes: The first stage is read only by the second stage.
`default_nettype none

module sshp_sync2 #(
    parameter WIDTH = 1
) (
    input wire CLK,
    input wire RST_N,
    input wire [WIDTH-1:0] D,
    output reg [WIDTH-1:0] Q
);

    reg [WIDTH-1:0] meta; // First stage, metastability catcher.

    // Shift the level through two stages.
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            meta <= {WIDTH{1'b0}};
            Q <= {WIDTH{1'b0}};
        end else begin
            meta <= D;
            Q <= meta;
        end
    end

endmodule // sshp_sync2
`default_nettype wire

// *** verification/sshp_host_port_properties.sv ***
// Purpose: Port assertions for the host port.
// Assumes: Pins pass two-flop synchronisers, so each rule waits a few samples.
// Notes: Bound to every instance of the host port.
`default_nettype none
module sshp_host_port_properties (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic RESET,
    input wire logic [15:0] HOST_DATA_OE,
    input wire logic [2:0] REGISTER_SELECT_LINES,
    input wire logic CHIP_ENABLE,
    input wire logic READ_WRITE,
    input wire logic BUS_STROBE,
    input wire logic LOOPBACK_TEST_MODE,
    input wire logic RECEIVER_ENABLE_IN,
    input wire logic TRANSMIT_CLOCK,
    input wire logic SERIAL_OUT,
    input wire logic TRANSMIT_BUFFER_EMPTY,
    input wire logic RECEIVE_DATA_AVAILABLE
);
    // -----------------------------------------------------------------
    // Bus drive and serial rules.
    // -----------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    AST_FLOAT_CE: assert property ((!CHIP_ENABLE)[*3] |=> HOST_DATA_OE == 16'h0000)
        else $error("bus driven with chip select low");
    AST_FLOAT_STB: assert property ((!BUS_STROBE)[*3] |=> HOST_DATA_OE == 16'h0000)
        else $error("bus driven with strobe low");
    AST_OE_READ: assert property ((CHIP_ENABLE && BUS_STROBE && !READ_WRITE)[*3]
        |=> HOST_DATA_OE == 16'hffff) else $error("read cycle does not drive bus");
    AST_OE_WRITE: assert property (READ_WRITE[*3] |=> HOST_DATA_OE == 16'h0000)
        else $error("bus driven during write");
    AST_LOOP_OUT: assert property (LOOPBACK_TEST_MODE[*4] |=> SERIAL_OUT)
        else $error("serial output not held high in loopback");
    AST_RESET_PIN: assert property (RESET[*5] |=> !TRANSMIT_BUFFER_EMPTY
        && !RECEIVE_DATA_AVAILABLE) else $error("reset pin left flags set");
    AST_RX_OFF: assert property ((!RECEIVER_ENABLE_IN)[*5] |=> !RECEIVE_DATA_AVAILABLE)
        else $error("data available while receiver disabled");
    AST_TBE_LOAD: assert property ((CHIP_ENABLE && BUS_STROBE && READ_WRITE &&
        REGISTER_SELECT_LINES[2:1] == 2'h3 && !TRANSMIT_CLOCK)[*6]
        |=> !TRANSMIT_BUFFER_EMPTY) else $error("buffer empty kept after transmit write");
endmodule // sshp_host_port_properties
bind sshp_host_port sshp_host_port_properties chk (.CLK, .RST_N, .RESET, .HOST_DATA_OE,
    .REGISTER_SELECT_LINES, .CHIP_ENABLE, .READ_WRITE, .BUS_STROBE, .LOOPBACK_TEST_MODE,
    .RECEIVER_ENABLE_IN, .TRANSMIT_CLOCK, .SERIAL_OUT, .TRANSMIT_BUFFER_EMPTY,
    .RECEIVE_DATA_AVAILABLE);
`default_nettype wire

// *** verification/sshp_host_model.sv ***
// Purpose: Host processor and serial line model facing the host port.
// Assumes: Pins change only at rising edges of clk.
// Notes: Released lines show the inverse of their last value.
`default_nettype none
module sshp_host_model (
    input wire logic clk,
    input wire logic [15:0] data_out,
    output logic [15:0] data_in,
    output logic [2:0] sel,
    output logic byte_mode,
    output logic ce,
    output logic rw,
    output logic strobe,
    output logic serial_in,
    output logic rx_clk
);
    // -----------------------------------------------------------------
    // Bus cycle: controls first, then a long strobe, then a long gap.
    // -----------------------------------------------------------------
    task automatic bus_op(input logic en, wr, bm, input logic [2:0] s,
            input logic [15:0] d, output logic [15:0] q);
        @(posedge clk);
        ce <= en;
        rw <= wr;
        sel <= s;
        byte_mode <= bm;
        data_in <= d;
        @(posedge clk);
        strobe <= 1'b1;
        repeat (6) @(posedge clk);
        q = data_out;
        strobe <= 1'b0;
        repeat (4) @(posedge clk);
        ce <= 1'b0;
        data_in <= ~d;
    endtask
    // -----------------------------------------------------------------
    // Serial character, first bit first; the clock stands still after.
    // -----------------------------------------------------------------
    task automatic send_char(input logic [7:0] c);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            serial_in <= c[i];
            rx_clk <= 1'b0;
            repeat (4) @(posedge clk);
            rx_clk <= 1'b1;
            repeat (3) @(posedge clk);
        end
        rx_clk <= 1'b0;
        serial_in <= ~c[7];
    endtask
    initial begin
        {data_in, sel, byte_mode, ce, rw, strobe, rx_clk} = '0;
        serial_in = 1'b1;
    end
endmodule // sshp_host_model
`default_nettype wire

// *** verification/sshp_host_port_test.sv ***
// Purpose: Self-checking bench for the host port.
// Assumes: Transmit clock idles low; only the loopback scenario toggles it.
// Notes: Each scenario is one task.
`default_nettype none
module sshp_host_port_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic reset = 1'b0;
    logic loop = 1'b0;
    logic rx_en = 1'b1;
    logic transmit_clock = 1'b0;
    logic [15:0] din, dout, oe, q;
    logic [2:0] sel;
    logic bm, ce, rw, stb, sin, receive_clock, sout, tbe, rda;
    int miscompares = 0;
    int cmp_count = 0;
    int cycles = 0;
    sshp_host_port dut (.CLK(clk), .RST_N(rst_n), .RESET(reset), .HOST_DATA_IN(din),
        .HOST_DATA_OUT(dout), .HOST_DATA_OE(oe), .REGISTER_SELECT_LINES(sel), .BYTE_MODE(bm),
        .CHIP_ENABLE(ce), .READ_WRITE(rw), .BUS_STROBE(stb), .LOOPBACK_TEST_MODE(loop),
        .RECEIVER_ENABLE_IN(rx_en), .SERIAL_IN(sin), .RECEIVE_CLOCK(receive_clock),
        .TRANSMIT_CLOCK(transmit_clock), .SERIAL_OUT(sout), .TRANSMIT_BUFFER_EMPTY(tbe),
        .RECEIVE_DATA_AVAILABLE(rda));
    sshp_host_model m (.clk(clk), .data_out(dout), .data_in(din), .sel(sel), .byte_mode(bm),
        .ce(ce), .rw(rw), .strobe(stb), .serial_in(sin), .rx_clk(receive_clock));
    initial begin
        forever #5 clk = ~clk;
    end
    // Compare and count; a mismatch is reported at once.
    task automatic check(input logic [15:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up;
        $display("Compares %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Word and byte access, with the unused byte lane reading zero.
    task automatic t_regs;
        m.bus_op(1, 1, 0, 3'h4, 16'ha5c3, q);
        m.bus_op(1, 0, 0, 3'h4, 16'h0000, q);
        check(q, 16'ha5c3);
        m.bus_op(1, 1, 1, 3'h5, 16'h3c3c, q);
        m.bus_op(1, 0, 0, 3'h4, 16'h0000, q);
        check(q, 16'h3cc3);
        m.bus_op(1, 0, 1, 3'h5, 16'h0000, q);
        check(q, 16'h3c00);
        m.bus_op(1, 0, 1, 3'h4, 16'h0000, q);
        check(q, 16'h00c3);
        m.bus_op(0, 1, 0, 3'h4, 16'h0000, q);
        m.bus_op(1, 0, 0, 3'h4, 16'h0000, q);
        check(q, 16'h3cc3);
        m.bus_op(1, 1, 0, 3'h6, 16'h0055, q);
        check(tbe, 16'h0000);
    endtask
    // Receive one character, read it, then lose one to a receiver disable.
    task automatic t_rx;
        m.send_char(8'h96);
        repeat (6) @(posedge clk);
        check(rda, 16'h0001);
        m.bus_op(1, 0, 1, 3'h1, 16'h0000, q);
        check(q, 16'h0000);
        check(rda, 16'h0001);
        m.bus_op(1, 0, 1, 3'h0, 16'h0000, q);
        check(q, 16'h0096);
        check(rda, 16'h0000);
        m.send_char(8'h5a);
        repeat (6) @(posedge clk);
        check(rda, 16'h0001);
        rx_en <= 1'b0;
        repeat (6) @(posedge clk);
        check(rda, 16'h0000);
        rx_en <= 1'b1;
    endtask
    // Loopback ignores the external line; the reset pin clears registers.
    task automatic t_mode;
        loop <= 1'b1;
        m.send_char(8'hc3);
        repeat (6) @(posedge clk);
        check(sout, 16'h0001);
        check(rda, 16'h0000);
        loop <= 1'b0;
        reset <= 1'b1;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        repeat (4) @(posedge clk);
        m.bus_op(1, 0, 0, 3'h4, 16'h0000, q);
        check(q, 16'h0000);
    endtask
    // Loopback: five transmit clock edges load the transmitter, empty its register and fill a 5-bit character
    // in the receiver, while the external serial output stays high.
    task automatic t_loop;
        m.bus_op(1, 1, 0, 3'h2, 16'h0300, q);
        m.bus_op(1, 1, 0, 3'h6, 16'h0055, q);
        loop <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            check(rda, 16'h0000);
            transmit_clock <= 1'b1;
            repeat (4) @(posedge clk);
            check(sout, 16'h0001);
            transmit_clock <= 1'b0;
            repeat (4) @(posedge clk);
        end
        check(rda, 16'h0001);
        check(tbe, 16'h0001);
        loop <= 1'b0;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        check(oe, 16'h0000);
        check(tbe, 16'h0001);
        t_regs;
        t_rx;
        t_mode;
        t_loop;
        wrap_up;
    end
    // A hung handshake ends the run as a failure.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares++;
            wrap_up;
        end
    end
endmodule // sshp_host_port_test
`default_nettype wire
